/* verilog/wer_pkg.sv */
/*
 * Constants for the wake, hold, restart and interrupt controller:
 * register offsets, field positions, reset values and interval counts.
 * Assumes a 100 MHz system clock.
 */
package wer_pkg;

	// Time base
	localparam int unsigned CLK_FREQ_HZ = 100_000_000;

	// Intervals in their own units
	localparam int unsigned T_WAKE_DLY_MS  = 50;
	localparam int unsigned T_HOLD_TMO_S   = 5;
	localparam int unsigned T_RST_MIN_S    = 1;
	localparam int unsigned T_IRQ_REARM_US = 32;

	// Interval counts in clock cycles
	localparam int unsigned WAKE_DLY_CYC  = CLK_FREQ_HZ / 1000 * T_WAKE_DLY_MS;
	localparam int unsigned HOLD_TMO_CYC  = CLK_FREQ_HZ * T_HOLD_TMO_S;
	localparam int unsigned RST_MIN_CYC   = CLK_FREQ_HZ * T_RST_MIN_S;
	localparam int unsigned IRQ_REARM_CYC = CLK_FREQ_HZ / 1_000_000 * T_IRQ_REARM_US;

	// Timer channels
	localparam int N_TMR     = 3;
	localparam int TMR_W     = 32;
	localparam int TMR_WAKE  = 0;
	localparam int TMR_HOLD  = 1;
	localparam int TMR_RST   = 2;

	// Register bus geometry
	localparam int ADDR_W = 4;
	localparam int DATA_W = 8;

	// Register offsets
	localparam logic [3:0] OFS_STATUS = 4'h0;
	localparam logic [3:0] OFS_INT    = 4'h1;
	localparam logic [3:0] OFS_MASK   = 4'h2;
	localparam logic [3:0] OFS_CTRL   = 4'h3;

	// Interrupt flag and mask fields
	localparam int IRQ_BTN   = 0;
	localparam int IRQ_USB   = 1;
	localparam int IRQ_AC    = 2;
	localparam int IRQ_FAULT = 3;
	localparam int IRQ_HTMO  = 4;
	localparam int N_IRQ     = 5;

	// Status fields
	localparam int STS_BTN     = 0;
	localparam int STS_USB     = 1;
	localparam int STS_AC      = 2;
	localparam int STS_ACTIVE  = 3;
	localparam int STS_SLEEP   = 4;
	localparam int STS_OFF_SEL = 5;

	// Control fields
	localparam int CTL_OFF_SEL = 0;

	// Reset values
	localparam logic [7:0] MASK_RST = 8'h00;
	localparam logic [7:0] CTRL_RST = 8'h01;

	typedef enum logic [2:0] {
		WER_OFF,
		WER_SLEEP,
		WER_WAKE_DLY,
		WER_WAIT_HOLD,
		WER_HOLD_EXT,
		WER_ACTIVE,
		WER_RESTART
	} wer_state_e;

endpackage : wer_pkg

/* verilog/wer_tmr_if.sv */
/*
 * Carrier between the controller and its interval timers.
 * Assumes one clock domain shared by both ends.
 */
`timescale 1ns/10ps
`default_nettype none
interface wer_tmr_if;
	import wer_pkg::*;
	logic [N_TMR-1:0]            run;
	logic [N_TMR-1:0][TMR_W-1:0] limit;
	logic [N_TMR-1:0]            done;

	modport ctl (output run, output limit, input done);
	modport tmr (input run, input limit, output done);
endinterface : wer_tmr_if
`default_nettype wire

/* verilog/wer_tmr.sv */
/*
 * Interval timers, one per channel, counting clock cycles while run is high.
 * Assumes limit is at least one and stable while run is high.
 */
`timescale 1ns/10ps
`default_nettype none
module wer_tmr
	import wer_pkg::*;
(
	// Clock and reset
	input  wire logic clk,
	input  wire logic sys_rst,
	input  wire logic ce,
	// Controller side
	wer_tmr_if.tmr    tif
);

	for (genvar i = 0; i < N_TMR; i++) begin : g_ch
		logic [TMR_W-1:0] cnt_q;
		logic             done_q;

		// Dropping run restarts the count from zero
		always_ff @(posedge clk) begin
			if (sys_rst) begin
				cnt_q  <= '0;
				done_q <= 1'b0;
			end else if (ce) begin
				if (!tif.run[i]) begin
					cnt_q  <= '0;
					done_q <= 1'b0;
				end else if (!done_q) begin
					cnt_q  <= cnt_q + 32'h1;
					done_q <= (cnt_q + 32'h1 == tif.limit[i]);
				end
			end
		end

		assign tif.done[i] = done_q;
	end

endmodule : wer_tmr
`default_nettype wire

/* verilog/wer_ctrl.sv */
/*
 * Wake request, power hold, hardware restart and interrupt controller.
 * Assumes all pin inputs are synchronous to clk and already debounced;
 * the open-drain pins are resolved outside from the enables.
 */
// Operation
// - In OFF or SLEEP, a wakeup event pulls the wake request pin low.
// - Wake request goes low 50 ms after wakeup, stays low 50 ms past hold.
// - No hold within 5 s of wake request: power down to OFF or SLEEP.
// - In ACTIVE the wake request pin is always released.
// - Hold input is level sampled; an early hold counts as valid.
// - Host toggles hold input to move between ACTIVE and SLEEP.
// - In SLEEP, asserting hold alone starts power-up.
// - Restart low powers down all rails, always-on too, and resets registers.
// - Stay down while restart is low, and at least 1 s.
// - After restart returns high, enter ACTIVE and power up.
// - Every event or fault sets its flag and pulls the interrupt low.
// - Reading the flag register clears flags and releases the interrupt.
// - Persistent fault keeps its flag; interrupt low again within 32 us.
// - Button press, button release, USB and AC changes raise interrupts.
// - Any button level change sets the button flag; level is readable.
// - Masks only gate the interrupt pin, never the flags or monitors.
`timescale 1ns/10ps
`default_nettype none
module wer_ctrl
	import wer_pkg::*;
#(
	parameter int unsigned WAKE_DLY = WAKE_DLY_CYC,
	parameter int unsigned HOLD_TMO = HOLD_TMO_CYC,
	parameter int unsigned RST_MIN  = RST_MIN_CYC
) (
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              sys_rst,
	input  wire logic              ce,
	// Register port
	input  wire logic [ADDR_W-1:0] reg_addr,
	input  wire logic [DATA_W-1:0] reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic      [DATA_W-1:0] reg_rdata,
	// Monitored pins
	input  wire logic              power_hold_in,
	input  wire logic              external_restart_n,
	input  wire logic              button_input_n,
	input  wire logic              usb_ok,
	input  wire logic              ac_ok,
	input  wire logic              fault_in,
	// Open-drain pins, enable low while pulling low
	output logic                   wake_request_n_o,
	output logic                   wake_request_n_oe_n,
	output logic                   irq_line_n_o,
	output logic                   irq_line_n_oe_n,
	// Rail control
	output logic                   rails_en,
	output logic                   aon_rails_en
);

	localparam int A_REARM = 3;

	wer_tmr_if tif ();

	wer_tmr u_tmr (
		.clk     (clk),
		.sys_rst (sys_rst),
		.ce      (ce),
		.tif     (tif)
	);

	wer_state_e             state_q;
	wer_state_e             state_d;
	logic                   btn_q;
	logic                   usb_q;
	logic                   ac_q;
	logic [N_IRQ-1:0]       flags_q;
	logic [N_IRQ-1:0]       flags_d;
	logic [N_IRQ-1:0]       set_vec;
	logic [N_IRQ-1:0]       mask_q;
	logic                   off_sel_q;
	logic [DATA_W-1:0]      rdata_q;
	logic                   wake_oe_n_q;
	logic                   irq_oe_n_q;
	logic                   rails_q;
	logic                   aon_q;
	logic                   wake_evt;
	logic                   hold_tmo;
	logic                   rd_int;
	logic                   wr_int;
	logic                   regs_rst;

	// Timer channels
	assign tif.run[TMR_WAKE] = (state_q == WER_WAKE_DLY) || (state_q == WER_HOLD_EXT);
	assign tif.run[TMR_HOLD] = (state_q == WER_WAIT_HOLD);
	assign tif.run[TMR_RST]  = (state_q == WER_RESTART);
	assign tif.limit[TMR_WAKE] = TMR_W'(WAKE_DLY);
	assign tif.limit[TMR_HOLD] = TMR_W'(HOLD_TMO);
	assign tif.limit[TMR_RST]  = TMR_W'(RST_MIN);

	// Previous pin levels for edge detection
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			btn_q <= 1'b1;
			usb_q <= 1'b0;
			ac_q  <= 1'b0;
		end else if (ce) begin
			btn_q <= button_input_n;
			usb_q <= usb_ok;
			ac_q  <= ac_ok;
		end
	end

	// Press, supply insertion or adapter insertion wakes the device
	assign wake_evt = (btn_q && !button_input_n) || (!usb_q && usb_ok) || (!ac_q && ac_ok);
	assign hold_tmo = (state_q == WER_WAIT_HOLD) && tif.done[TMR_HOLD] && !power_hold_in;

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			WER_OFF: begin
				if (wake_evt) begin
					state_d = WER_WAKE_DLY;
				end
			end
			WER_SLEEP: begin
				if (wake_evt || power_hold_in) begin
					state_d = WER_WAKE_DLY;
				end
			end
			WER_WAKE_DLY: begin
				if (tif.done[TMR_WAKE]) begin
					state_d = WER_WAIT_HOLD;
				end
			end
			WER_WAIT_HOLD: begin
				// Level test, so a hold already high passes at once
				if (power_hold_in) begin
					state_d = WER_HOLD_EXT;
				end else if (tif.done[TMR_HOLD]) begin
					state_d = off_sel_q ? WER_OFF : WER_SLEEP;
				end
			end
			WER_HOLD_EXT: begin
				if (tif.done[TMR_WAKE]) begin
					state_d = WER_ACTIVE;
				end
			end
			WER_ACTIVE: begin
				if (!power_hold_in) begin
					state_d = off_sel_q ? WER_OFF : WER_SLEEP;
				end
			end
			WER_RESTART: begin
				if (external_restart_n && tif.done[TMR_RST]) begin
					state_d = WER_ACTIVE;
				end
			end
			default: state_d = WER_OFF;
		endcase
		if (!external_restart_n) begin
			state_d = WER_RESTART;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_q <= WER_OFF;
		end else if (ce) begin
			state_q <= state_d;
		end
	end

	// Pins and rails follow the next state so they leave a flop
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			wake_oe_n_q <= 1'b1;
			rails_q     <= 1'b0;
			aon_q       <= 1'b0;
		end else if (ce) begin
			wake_oe_n_q <= !((state_d == WER_WAIT_HOLD) || (state_d == WER_HOLD_EXT));
			rails_q     <= (state_d != WER_OFF) && (state_d != WER_SLEEP)
				&& (state_d != WER_RESTART);
			aon_q       <= (state_d != WER_OFF) && (state_d != WER_RESTART);
		end
	end

	// Register access decode; restart also brings registers to defaults
	assign rd_int   = reg_rd && (reg_addr == OFS_INT);
	assign wr_int   = reg_wr && (reg_addr == OFS_INT);
	assign regs_rst = sys_rst || (ce && !external_restart_n);

	always_comb begin
		set_vec            = '0;
		set_vec[IRQ_BTN]   = btn_q != button_input_n;
		set_vec[IRQ_USB]   = usb_q != usb_ok;
		set_vec[IRQ_AC]    = ac_q != ac_ok;
		set_vec[IRQ_FAULT] = fault_in;
		set_vec[IRQ_HTMO]  = hold_tmo;
		flags_d = flags_q;
		if (rd_int) begin
			flags_d = '0;
		end else if (wr_int) begin
			flags_d = flags_q & ~reg_wdata[N_IRQ-1:0];
		end
		// A new event in the clearing cycle is kept
		flags_d = flags_d | set_vec;
	end

	always_ff @(posedge clk) begin
		if (regs_rst) begin
			flags_q <= '0;
		end else if (ce) begin
			flags_q <= flags_d;
		end
	end

	always_ff @(posedge clk) begin
		if (regs_rst) begin
			mask_q    <= MASK_RST[N_IRQ-1:0];
			off_sel_q <= CTRL_RST[CTL_OFF_SEL];
		end else if (ce && reg_wr) begin
			if (reg_addr == OFS_MASK) begin
				mask_q <= reg_wdata[N_IRQ-1:0];
			end
			if (reg_addr == OFS_CTRL) begin
				off_sel_q <= reg_wdata[CTL_OFF_SEL];
			end
		end
	end

	// Masks gate the pin only; flags keep recording
	always_ff @(posedge clk) begin
		if (regs_rst) begin
			irq_oe_n_q <= 1'b1;
		end else if (ce) begin
			irq_oe_n_q <= ~|(flags_d & ~mask_q);
		end
	end

	// Read data stand for one cycle only, zero otherwise
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rdata_q <= '0;
		end else if (ce) begin
			rdata_q <= '0;
			if (reg_rd) begin
				unique case (reg_addr)
					OFS_STATUS: begin
						rdata_q[STS_BTN]     <= !button_input_n;
						rdata_q[STS_USB]     <= usb_ok;
						rdata_q[STS_AC]      <= ac_ok;
						rdata_q[STS_ACTIVE]  <= state_q == WER_ACTIVE;
						rdata_q[STS_SLEEP]   <= state_q == WER_SLEEP;
						rdata_q[STS_OFF_SEL] <= off_sel_q;
					end
					OFS_INT:  rdata_q[N_IRQ-1:0] <= flags_q;
					OFS_MASK: rdata_q[N_IRQ-1:0] <= mask_q;
					OFS_CTRL: rdata_q[CTL_OFF_SEL] <= off_sel_q;
					default:  rdata_q <= '0;
				endcase
			end
		end
	end

	assign reg_rdata           = rdata_q;
	assign wake_request_n_o    = 1'b0;
	assign wake_request_n_oe_n = wake_oe_n_q;
	assign irq_line_n_o        = 1'b0;
	assign irq_line_n_oe_n     = irq_oe_n_q;
	assign rails_en            = rails_q;
	assign aon_rails_en        = aon_q;

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	a_wake_pin_low: assert property (
		(state_q == WER_WAIT_HOLD || state_q == WER_HOLD_EXT) |-> !wake_oe_n_q)
		else $error("wake request not pulled low while waiting for hold");
	a_wake_dly_high: assert property (
		ce && state_q == WER_OFF && wake_evt && external_restart_n |=> wake_oe_n_q [*2])
		else $error("wake request pulled low before its delay");
	a_hold_timeout: assert property (
		ce && hold_tmo && external_restart_n
		|=> state_q == (off_sel_q ? WER_OFF : WER_SLEEP) && aon_q == !off_sel_q)
		else $error("hold timeout did not power down as selected");
	a_active_release: assert property (
		state_q == WER_ACTIVE |-> wake_oe_n_q)
		else $error("wake request low in active state");
	a_hold_level: assert property (
		ce && state_q == WER_WAIT_HOLD && power_hold_in && external_restart_n
		|=> state_q == WER_HOLD_EXT)
		else $error("hold level not accepted");
	a_active_sleep: assert property (
		ce && state_q == WER_ACTIVE && !power_hold_in && external_restart_n
		|=> state_q != WER_ACTIVE && !rails_q)
		else $error("hold drop did not leave active state");
	a_sleep_wake: assert property (
		ce && state_q == WER_SLEEP && power_hold_in && external_restart_n
		|=> state_q == WER_WAKE_DLY && rails_q)
		else $error("hold alone did not wake from sleep");
	a_restart_down: assert property (
		ce && !external_restart_n
		|=> state_q == WER_RESTART && !aon_q && !rails_q && flags_q == '0)
		else $error("restart did not power down everything");
	a_restart_min: assert property (
		state_q == WER_RESTART && !tif.done[TMR_RST] |=> state_q == WER_RESTART)
		else $error("restart left before its minimum time");
	a_restart_exit: assert property (
		ce && state_q == WER_RESTART && tif.done[TMR_RST] && external_restart_n
		|=> state_q == WER_ACTIVE && rails_q)
		else $error("restart release did not enter active");
	a_fault_irq: assert property (
		ce && fault_in && !mask_q[IRQ_FAULT] && external_restart_n
		|-> ##[1:A_REARM] !irq_oe_n_q)
		else $error("persistent fault did not pull interrupt low");
	a_read_clear: assert property (
		ce && rd_int && set_vec == '0 && external_restart_n
		|=> flags_q == '0 && irq_oe_n_q)
		else $error("flag read did not clear and release");
	a_btn_flag: assert property (
		ce && (btn_q != button_input_n) && external_restart_n |=> flags_q[IRQ_BTN])
		else $error("button change flag not set");
	a_usb_flag: assert property (
		ce && (usb_q != usb_ok) && external_restart_n |=> flags_q[IRQ_USB])
		else $error("supply change flag not set");
	a_ac_flag: assert property (
		ce && (ac_q != ac_ok) && external_restart_n |=> flags_q[IRQ_AC])
		else $error("adapter change flag not set");
	// Flags keep recording even while the pin is masked
	a_masked_flag: assert property (
		ce && fault_in && mask_q[IRQ_FAULT] && external_restart_n |=> flags_q[IRQ_FAULT])
		else $error("masked fault not recorded");
	a_event_pin: assert property (
		ce && (ac_q != ac_ok) && !mask_q[IRQ_AC] && !(reg_wr && reg_addr == OFS_MASK)
		&& external_restart_n |=> !irq_oe_n_q)
		else $error("unmasked event did not pull interrupt low");

	c_reach_active: cover property (state_q == WER_HOLD_EXT ##1 state_q == WER_ACTIVE);
	c_hold_timeout: cover property (hold_tmo);
	c_restart_exit: cover property (state_q == WER_RESTART ##1 state_q == WER_ACTIVE);
	c_irq_cleared:  cover property (!irq_oe_n_q ##1 irq_oe_n_q);
	c_masked_fault: cover property (fault_in && mask_q[IRQ_FAULT] && irq_oe_n_q);

endmodule : wer_ctrl
`default_nettype wire

/* testbench/wer_host_model.sv */
/* Host processor model: pull-ups on both open-drain lines, and a
 * hold output raised some cycles after the wake line goes low.
 * Assumes the bench sets answer, early and lat between edges. */
`timescale 1ns/10ps
`default_nettype none
module wer_host_model (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       sys_rst,
	// Device pins
	input  wire logic       wake_o,
	input  wire logic       wake_oe_n,
	input  wire logic       irq_o,
	input  wire logic       irq_oe_n,
	output logic            wake_pin_n,
	output logic            irq_pin_n,
	output logic            power_hold_in,
	// Bench commands
	input  wire logic       answer,
	input  wire logic       early,
	input  wire logic [7:0] lat
);
	logic [7:0] cnt_q;
	logic       pull_q;

	// Released lines float to the pull-up level
	assign wake_pin_n    = wake_oe_n ? 1'b1 : wake_o;
	assign irq_pin_n     = irq_oe_n ? 1'b1 : irq_o;
	assign power_hold_in = early | pull_q;

	// Slow answers use a large lat, still inside the hold timeout
	always_ff @(posedge clk) begin
		if (sys_rst || !answer) begin
			cnt_q  <= 8'h00;
			pull_q <= 1'b0;
		end else if (!wake_pin_n && !pull_q) begin
			cnt_q  <= cnt_q + 8'h01;
			pull_q <= (cnt_q >= lat);
		end
	end
endmodule : wer_host_model
`default_nettype wire

/* testbench/wer_ctrl_test.sv */
/* Self-checking bench for the wake, hold, restart and interrupt block.
 * Assumes the host model stands on the pins; counts are shortened. */
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
	$display("BAD %s exp=%0h got=%0h", nm, e, g); end end
module wer_ctrl_test;
	import wer_pkg::*;
	localparam int WD = 8;
	localparam int HT = 40;
	localparam int RM = 16;
	logic       clk, sys_rst, reg_wr, reg_rd, ext_n, btn_n, usb, ac, fault, ce;
	logic       answer, early, rails, aon, wake_o, wake_oe_n, irq_o, irq_oe_n;
	logic       wake_n, irq_n, hold;
	logic [3:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, rv, lat;
	int         error_cnt, tests_run, n;

	wer_ctrl #(.WAKE_DLY(WD), .HOLD_TMO(HT), .RST_MIN(RM)) DUT (
		.clk(clk), .sys_rst(sys_rst), .ce(ce), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.power_hold_in(hold), .external_restart_n(ext_n), .button_input_n(btn_n),
		.usb_ok(usb), .ac_ok(ac), .fault_in(fault), .wake_request_n_o(wake_o),
		.wake_request_n_oe_n(wake_oe_n), .irq_line_n_o(irq_o),
		.irq_line_n_oe_n(irq_oe_n), .rails_en(rails), .aon_rails_en(aon));
	wer_host_model host (
		.clk(clk), .sys_rst(sys_rst), .wake_o(wake_o), .wake_oe_n(wake_oe_n),
		.irq_o(irq_o), .irq_oe_n(irq_oe_n), .wake_pin_n(wake_n), .irq_pin_n(irq_n),
		.power_hold_in(hold), .answer(answer), .early(early), .lat(lat));

	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask : cyc
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		// Leave the edge step so a following write does not set the strobe twice
		#1;
	endtask : wr
	// Data stand only in the cycle after the read edge
	task automatic rd(input logic [3:0] a);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 rv = reg_rdata;
	endtask : rd
	function automatic logic sig(input int s);
		return s == 0 ? wake_n : (s == 1 ? rails : irq_n);
	endfunction : sig
	task automatic wt(input int s, input logic v, input int mx);
		n = 0;
		while (sig(s) !== v && n < mx) begin
			@(posedge clk);
			#1 n++;
		end
	endtask : wt
	task automatic finish_test;
		$display("checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : finish_test

	task automatic t_reset;
		logic [3:0] a [5] = '{OFS_STATUS, OFS_INT, OFS_MASK, OFS_CTRL, 4'h7};
		logic [7:0] e [5] = '{8'h20, 8'h00, MASK_RST, CTRL_RST, 8'h00};
		`CHK("rails", 2'b00, {rails, aon})
		`CHK("pins", 2'b11, {wake_n, irq_n})
		wr(OFS_STATUS, 8'hff);
		foreach (a[i]) begin
			rd(a[i]);
			`CHK("reg", e[i], rv)
		end
	endtask : t_reset
	task automatic t_early;
		early <= 1'b1;
		cyc(5);
		`CHK("off_hold", 1'b0, rails)
		ac <= 1'b1;
		cyc(2);
		`CHK("wake_rails", 2'b11, {rails, aon})
		wt(0, 1'b0, 30);
		`CHK("wake_dly", 1'b1, n >= WD - 2 && n <= WD + 3)
		wt(0, 1'b1, 30);
		`CHK("wake_hold", 1'b1, n >= WD && n <= WD + 4)
		usb <= 1'b1;
		cyc(20);
		`CHK("active_wake", 1'b1, wake_n)
		`CHK("irq_low", 1'b0, irq_n)
		rd(OFS_STATUS);
		`CHK("status", 8'h2e, rv)
		rd(OFS_INT);
		`CHK("int", 8'h06, rv)
		cyc(2);
		`CHK("irq_rel", 1'b1, irq_n)
	endtask : t_early
	task automatic t_sleep;
		early <= 1'b0;
		cyc(3);
		`CHK("hold_off", 2'b00, {rails, aon})
		wr(OFS_CTRL, 8'h00);
		lat    <= 8'h14;
		answer <= 1'b1;
		btn_n  <= 1'b0;
		wt(0, 1'b0, 30);
		wt(0, 1'b1, 60);
		rd(OFS_STATUS);
		`CHK("btn_sts", 8'h0f, rv)
		rd(OFS_INT);
		`CHK("btn_fall", 8'h01, rv)
		btn_n  <= 1'b1;
		answer <= 1'b0;
		cyc(3);
		`CHK("to_sleep", 2'b01, {rails, aon})
		rd(OFS_INT);
		`CHK("btn_rise", 8'h01, rv)
		early <= 1'b1;
		cyc(3);
		`CHK("sleep_up", 1'b1, rails)
		wt(0, 1'b0, 30);
		wt(0, 1'b1, 30);
		early <= 1'b0;
		cyc(3);
		`CHK("resleep", 2'b01, {rails, aon})
	endtask : t_sleep
	task automatic t_timeout;
		usb <= 1'b0;
		cyc(2);
		rd(OFS_INT);
		usb <= 1'b1;
		wt(0, 1'b0, 30);
		wt(1, 1'b0, 60);
		`CHK("tmo", 1'b1, n >= HT - 1 && n <= HT + 4)
		cyc(2);
		`CHK("tmo_sleep", 2'b11, {wake_n, aon})
		rd(OFS_INT);
		`CHK("tmo_flag", 8'h12, rv)
		wr(OFS_CTRL, 8'h01);
		btn_n <= 1'b0;
		wt(0, 1'b0, 30);
		wt(1, 1'b0, 60);
		cyc(2);
		`CHK("tmo_off", 1'b0, aon)
		btn_n <= 1'b1;
		cyc(2);
	endtask : t_timeout
	task automatic t_irq;
		rd(OFS_INT);
		// Persistent fault would hold the line, so the host masks it
		wr(OFS_MASK, 8'h08);
		fault <= 1'b1;
		cyc(3);
		`CHK("masked_pin", 1'b1, irq_n)
		rd(OFS_INT);
		`CHK("masked_flag", 8'h08, rv)
		rd(OFS_INT);
		`CHK("persist", 8'h08, rv)
		wr(OFS_MASK, 8'h00);
		cyc(2);
		`CHK("unmask", 1'b0, irq_n)
		rd(OFS_INT);
		cyc(2);
		`CHK("rearm", 1'b0, irq_n)
		fault <= 1'b0;
		rd(OFS_INT);
		rd(OFS_INT);
		`CHK("clear", 8'h00, rv)
		usb <= 1'b0;
		cyc(2);
		wr(OFS_INT, 8'h02);
		rd(OFS_INT);
		`CHK("w1c", 8'h00, rv)
		cyc(2);
		`CHK("irq_idle", 1'b1, irq_n)
		// Clock enable low freezes the edge detector, flags and pin
		ce <= 1'b0;
		ac <= 1'b0;
		cyc(3);
		`CHK("frozen", 1'b1, irq_n)
		ce <= 1'b1;
		cyc(2);
		`CHK("thawed", 1'b0, irq_n)
		rd(OFS_INT);
		`CHK("ac_fall", 8'h04, rv)
	endtask : t_irq
	task automatic t_restart;
		wr(OFS_MASK, 8'h1f);
		wr(OFS_CTRL, 8'h00);
		early <= 1'b1;
		ext_n <= 1'b0;
		cyc(3);
		`CHK("rst_down", 2'b00, {rails, aon})
		ext_n <= 1'b1;
		wt(1, 1'b1, 40);
		`CHK("rst_min", 1'b1, n >= RM - 3 && n <= RM + 2)
		rd(OFS_MASK);
		`CHK("rst_mask", MASK_RST, rv)
		rd(OFS_CTRL);
		`CHK("rst_ctrl", CTRL_RST, rv)
		ext_n <= 1'b0;
		cyc(2 * RM);
		`CHK("rst_long", 2'b00, {rails, aon})
		ext_n <= 1'b1;
		cyc(3);
		`CHK("rst_act", 2'b11, {rails, aon})
		rd(OFS_STATUS);
		`CHK("rst_sts", 8'h28, rv)
	endtask : t_restart

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		{sys_rst, ext_n, btn_n, ce} = 4'hf;
		{reg_wr, reg_rd, usb, ac, fault, answer, early} = 7'h00;
		reg_addr  = 4'h0;
		reg_wdata = 8'h00;
		lat       = 8'h01;
		error_cnt = 0;
		tests_run = 0;
		repeat (8) @(posedge clk);
		sys_rst <= 1'b0;
		cyc(1);
		t_reset;
		t_early;
		t_sleep;
		t_timeout;
		t_irq;
		t_restart;
		finish_test;
	end
	// Whole run needs about 350 cycles
	initial begin
		repeat (5000) @(posedge clk);
		error_cnt++;
		finish_test;
	end
endmodule : wer_ctrl_test
`default_nettype wire
